// ### inc/ecppf_defines.svh
/*
 Constants of the extended parallel port engine: mode codes,
 FIFO geometry and field positions.
 Assumes inclusion by bare name from the design file.
*/
`ifndef ECPPF_DEFINES_SVH
`define ECPPF_DEFINES_SVH
// Port mode codes
`define ECPPF_MODE_SPP   3'h0
`define ECPPF_MODE_PS2   3'h1
`define ECPPF_MODE_FIFO  3'h2
`define ECPPF_MODE_ECP   3'h3
// FIFO geometry
`define ECPPF_FIFO_DEPTH 16
`define ECPPF_DATA_W     8
`define ECPPF_WORD_W     9
// Synchroniser vector: error, confirm, cmd flag, valid, data
`define ECPPF_SYNC_W     12
`define ECPPF_SYNC_ERR   11
`define ECPPF_SYNC_CONF  10
`define ECPPF_SYNC_CMD   9
`define ECPPF_SYNC_VAL   8
// Reset values
`define ECPPF_RST_MODE   3'h0
`define ECPPF_RST_SYNC   12'hF00
`endif

// ### inc/ecppf_pkg.sv
/*
 Types of the extended parallel port engine.
 Assumes the defines header is compiled alongside.
*/
package ecppf_pkg;
   // Engine states
   typedef enum logic [2:0] {
      ST_IDLE, ST_FWD_SETUP, ST_FWD_STROBE, ST_FWD_RELEASE,
      ST_REV_WAIT, ST_REV_ACK
   } ecppf_state_t;
   // One FIFO entry: command tag and byte
   typedef struct packed {
      logic       cmd;
      logic [7:0] data;
   } ecppf_word_t;
   // Pin levels software drives in the basic modes
   typedef struct packed {
      logic       strobe_n;
      logic       auto_feed_n;
      logic       init_n;
      logic       select_in_n;
      logic       data_oe;
      logic [7:0] data;
   } ecppf_swpins_t;
endpackage : ecppf_pkg

// ### design/ecppf_parallel_port.sv
/*
 Extended parallel port engine with its byte FIFO.
 Assumes one 25 MHz clock, a synchronous active-low reset, and
 a board that resolves the data bus from the output enable.
*/
`timescale 1ns/10ps
`default_nettype none
`include "ecppf_defines.svh"

// Byte FIFO with count-derived flags
module ecppf_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8,
   parameter int CW    = $clog2(DEPTH + 1)
) (
   // Clock and reset
   input  wire logic             i_sys_clk,
   input  wire logic             i_rst_n,
   input  wire logic             i_flush,
   // Fill side
   input  wire logic             i_in_valid,
   output logic                  o_in_ready,
   input  wire logic [WIDTH-1:0] i_in_data,
   // Drain side
   output logic                  o_out_valid,
   input  wire logic             i_out_ready,
   output logic [WIDTH-1:0]      o_out_data,
   // Fill level
   output logic [CW-1:0]         o_count,
   output logic                  o_full,
   output logic                  o_empty
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_ptr_q;
   logic [AW-1:0]    rd_ptr_q;
   logic [CW-1:0]    cnt_q;
   logic [CW-1:0]    cnt_d;
   logic             push;
   logic             pop;

   assign push        = i_in_valid & ~o_full;
   assign pop         = ~o_empty & i_out_ready;
   assign o_in_ready  = ~o_full;
   assign o_out_valid = ~o_empty;
   assign o_out_data  = mem_q[rd_ptr_q];
   assign o_count     = cnt_q;

   // Level after this edge
   always_comb begin
      cnt_d = cnt_q;
      if (i_flush) begin
         cnt_d = '0;
      end else if (push && !pop) begin
         cnt_d = cnt_q + CW'(1);
      end else if (pop && !push) begin
         cnt_d = cnt_q - CW'(1);
      end
   end

   // Storage has no reset; only pointers matter
   always_ff @(posedge i_sys_clk) begin
      if (push) begin
         mem_q[wr_ptr_q] <= i_in_data;
      end
   end

   // Pointers wrap at DEPTH, which need not be a power of two
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n || i_flush) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + AW'(1);
         end
         if (pop) begin
            rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + AW'(1);
         end
      end
   end

   // Count and flags
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         cnt_q   <= '0;
         o_full  <= 1'b0;
         o_empty <= 1'b1;
      end else begin
         cnt_q   <= cnt_d;
         o_full  <= (cnt_d == CW'(DEPTH));
         o_empty <= (cnt_d == '0);
      end
   end
endmodule : ecppf_fifo

module ecppf_parallel_port #(
   parameter int DEPTH = `ECPPF_FIFO_DEPTH,
   parameter int CW    = $clog2(DEPTH + 1)
) (
   // Clock and reset
   input  wire logic                  i_sys_clk,
   input  wire logic                  i_rst_n,
   // Configuration
   input  wire logic [2:0]            i_mode,
   input  wire logic                  i_mode_wr,
   input  wire logic                  i_dir,
   input  wire logic                  i_dir_wr,
   input  wire logic                  i_dma_enable_bit,
   input  wire logic                  i_dma_tc,
   input  wire logic                  i_svc_clr,
   input  wire logic                  i_fault_int_dis,
   input  wire logic                  i_fault_clr,
   input  wire logic [3:0]            i_fifo_threshold_config,
   input  wire ecppf_pkg::ecppf_swpins_t i_sw_pins,
   // Host write into the one FIFO: sel 1 tags a command byte in ECP mode, sel 0 data
   input  wire logic                  i_wr_valid,
   input  wire logic                  i_wr_addr_sel,
   input  wire logic [7:0]            i_wr_data,
   output logic                       o_wr_ready,
   // Host read of reverse bytes
   output logic                       o_rd_valid,
   output ecppf_pkg::ecppf_word_t     o_rd_word,
   input  wire logic                  i_rd_ready,
   // Status
   output logic [2:0]                 o_mode,
   output logic                       o_dir,
   output logic                       o_fifo_full,
   output logic                       o_fifo_empty,
   output logic                       o_service_interrupt_bit,
   output logic                       o_fault_flag,
   output logic                       o_irq,
   output logic                       o_port_dma_request,
   // Port pins
   output logic                       o_host_write_strobe_n,
   output logic                       o_auto_feed_line_n,
   output logic                       o_reverse_direction_request_n,
   output logic                       o_select_input_line_n,
   output logic [7:0]                 o_port_data_bus,
   output logic                       o_port_data_bus_oe,
   input  wire logic [7:0]            i_port_data_bus,
   input  wire logic                  i_peripheral_valid_line_n,
   input  wire logic                  i_peripheral_cmd_flag,
   input  wire logic                  i_reverse_confirm_line_n,
   input  wire logic                  i_peripheral_error_line_n
);
   ecppf_pkg::ecppf_state_t state_q;
   ecppf_pkg::ecppf_word_t  rev_word_q;
   ecppf_pkg::ecppf_word_t  fifo_in_word;
   ecppf_pkg::ecppf_word_t  fifo_out_word;
   logic [`ECPPF_SYNC_W-1:0] sync1_q;
   logic [`ECPPF_SYNC_W-1:0] sync2_q;
   logic          err_prev_q;
   logic          rev_push_q;
   logic          fifo_in_valid;
   logic          fifo_in_ready;
   logic          fifo_out_valid;
   logic          fifo_out_ready;
   logic [CW-1:0] fifo_count;
   logic          host_push;
   logic          eng_pop;
   logic          rd_load;
   logic          auto_on;
   logic          ecp_on;
   logic          wr_ready_d;
   logic [CW-1:0] thr;
   logic          err_fall;

   // A mode counts as basic when software owns the lines
   function automatic logic is_basic(input logic [2:0] m);
      is_basic = (m == `ECPPF_MODE_SPP) || (m == `ECPPF_MODE_PS2);
   endfunction : is_basic

   assign auto_on  = (o_mode == `ECPPF_MODE_ECP)
                  || (o_mode == `ECPPF_MODE_FIFO);
   assign ecp_on   = (o_mode == `ECPPF_MODE_ECP);
   assign thr      = CW'(i_fifo_threshold_config);
   assign err_fall = err_prev_q & ~sync2_q[`ECPPF_SYNC_ERR];

   // Pins pass two flip-flops; only the second stage is read
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         sync1_q <= `ECPPF_RST_SYNC;
         sync2_q <= `ECPPF_RST_SYNC;
      end else begin
         sync1_q <= {i_peripheral_error_line_n, i_reverse_confirm_line_n,
                     i_peripheral_cmd_flag, i_peripheral_valid_line_n,
                     i_port_data_bus};
         sync2_q <= sync1_q;
      end
   end

   // Mode and direction; illegal changes are silently dropped
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         o_mode <= `ECPPF_RST_MODE;
         o_dir  <= 1'b0;
      end else begin
         if (i_mode_wr && (is_basic(o_mode) || is_basic(i_mode))) begin
            o_mode <= i_mode;
         end
         if (i_dir_wr && o_mode == `ECPPF_MODE_PS2) begin
            o_dir <= i_dir;
         end
      end
   end

   // Host fills forward; engine fills reverse
   assign host_push     = i_wr_valid & o_wr_ready;
   assign fifo_in_valid = o_dir ? rev_push_q : host_push;
   assign fifo_in_word  = o_dir ? rev_word_q : ecppf_pkg::ecppf_word_t'{
                             cmd: i_wr_addr_sel & ecp_on,
                             data: i_wr_data};
   assign eng_pop       = (state_q == ecppf_pkg::ST_IDLE) & auto_on
                        & ~o_dir & fifo_out_valid;
   assign rd_load       = o_dir & fifo_out_valid
                        & (~o_rd_valid | i_rd_ready);
   assign fifo_out_ready = o_dir ? rd_load : eng_pop;

   // Flushed outside FIFO modes, so it is idle after reset
   ecppf_fifo #(
      .WIDTH (`ECPPF_WORD_W),
      .DEPTH (DEPTH),
      .CW    (CW)
   ) u_fifo (
      .i_sys_clk   (i_sys_clk),
      .i_rst_n     (i_rst_n),
      .i_flush     (~auto_on),
      .i_in_valid  (fifo_in_valid),
      .o_in_ready  (fifo_in_ready),
      .i_in_data   (fifo_in_word),
      .o_out_valid (fifo_out_valid),
      .i_out_ready (fifo_out_ready),
      .o_out_data  (fifo_out_word),
      .o_count     (fifo_count),
      .o_full      (o_fifo_full),
      .o_empty     (o_fifo_empty)
   );

   // Registered ready looks one push ahead to avoid overrun
   assign wr_ready_d = auto_on & ~o_dir & ~i_mode_wr
      & (({1'b0, fifo_count} + {{CW{1'b0}}, host_push})
         < (CW + 1)'(DEPTH));
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         o_wr_ready <= 1'b0;
      end else begin
         o_wr_ready <= wr_ready_d;
      end
   end

   // Output stage for reverse bytes read by the host
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n || !auto_on) begin
         o_rd_valid <= 1'b0;
         o_rd_word  <= '0;
      end else if (rd_load) begin
         o_rd_valid <= 1'b1;
         o_rd_word  <= fifo_out_word;
      end else if (i_rd_ready) begin
         o_rd_valid <= 1'b0;
      end
   end

   // Handshake engine; command bit 7 is passed on untouched
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         state_q               <= ecppf_pkg::ST_IDLE;
         o_host_write_strobe_n <= 1'b1;
         o_auto_feed_line_n    <= 1'b1;
         o_port_data_bus       <= 8'h00;
         rev_push_q            <= 1'b0;
         rev_word_q            <= '0;
      end else begin
         rev_push_q <= 1'b0;
         case (state_q)
            ecppf_pkg::ST_IDLE: begin
               o_host_write_strobe_n <= 1'b1;
               o_auto_feed_line_n    <= 1'b1;
               if (!auto_on) begin
                  o_host_write_strobe_n <= i_sw_pins.strobe_n;
                  o_auto_feed_line_n    <= i_sw_pins.auto_feed_n;
                  o_port_data_bus       <= i_sw_pins.data;
               end else if (eng_pop) begin
                  o_port_data_bus    <= fifo_out_word.data;
                  o_auto_feed_line_n <= ~fifo_out_word.cmd;
                  state_q            <= ecppf_pkg::ST_FWD_SETUP;
               end else if (o_dir && ecp_on
                            && !sync2_q[`ECPPF_SYNC_CONF]) begin
                  o_auto_feed_line_n <= 1'b0;
                  state_q            <= ecppf_pkg::ST_REV_WAIT;
               end
            end
            ecppf_pkg::ST_FWD_SETUP: begin
               // Busy low: peripheral can take the byte
               if (!sync2_q[`ECPPF_SYNC_CMD]) begin
                  o_host_write_strobe_n <= 1'b0;
                  state_q               <= ecppf_pkg::ST_FWD_STROBE;
               end
            end
            ecppf_pkg::ST_FWD_STROBE: begin
               if (sync2_q[`ECPPF_SYNC_CMD]) begin
                  o_host_write_strobe_n <= 1'b1;
                  state_q               <= ecppf_pkg::ST_FWD_RELEASE;
               end
            end
            ecppf_pkg::ST_FWD_RELEASE: begin
               if (!sync2_q[`ECPPF_SYNC_CMD]) begin
                  o_auto_feed_line_n <= 1'b1;
                  state_q            <= ecppf_pkg::ST_IDLE;
               end
            end
            ecppf_pkg::ST_REV_WAIT: begin
               // Stall the peripheral while the FIFO is full
               if (!sync2_q[`ECPPF_SYNC_VAL] && fifo_in_ready) begin
                  rev_word_q <= '{cmd: ~sync2_q[`ECPPF_SYNC_CMD],
                                  data: sync2_q[7:0]};
                  rev_push_q         <= 1'b1;
                  o_auto_feed_line_n <= 1'b1;
                  state_q            <= ecppf_pkg::ST_REV_ACK;
               end
            end
            ecppf_pkg::ST_REV_ACK: begin
               if (sync2_q[`ECPPF_SYNC_VAL]) begin
                  state_q <= ecppf_pkg::ST_IDLE;
               end
            end
            default: begin
               state_q <= ecppf_pkg::ST_IDLE;
            end
         endcase
         // Leaving a FIFO mode aborts any transfer
         if (i_mode_wr || !auto_on) begin
            state_q <= ecppf_pkg::ST_IDLE;
         end
      end
   end

   // Direction, select-in and bus drive
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         o_reverse_direction_request_n <= 1'b1;
         o_select_input_line_n         <= 1'b1;
         o_port_data_bus_oe            <= 1'b0;
      end else if (ecp_on) begin
         o_reverse_direction_request_n <= ~o_dir;
         o_select_input_line_n         <= 1'b1;
         o_port_data_bus_oe <= ~o_dir & sync2_q[`ECPPF_SYNC_CONF];
      end else if (auto_on) begin
         o_reverse_direction_request_n <= i_sw_pins.init_n;
         o_select_input_line_n         <= i_sw_pins.select_in_n;
         o_port_data_bus_oe            <= 1'b1;
      end else begin
         o_reverse_direction_request_n <= i_sw_pins.init_n;
         o_select_input_line_n         <= i_sw_pins.select_in_n;
         o_port_data_bus_oe            <= i_sw_pins.data_oe & ~o_dir;
      end
   end

   // Service bit: a new event wins over a clear
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         o_service_interrupt_bit <= 1'b0;
      end else if (auto_on && i_dma_enable_bit && i_dma_tc) begin
         o_service_interrupt_bit <= 1'b1;
      end else if (auto_on && !i_dma_enable_bit && !o_dir
                   && (CW'(DEPTH) - fifo_count) >= thr) begin
         o_service_interrupt_bit <= 1'b1;
      end else if (auto_on && !i_dma_enable_bit && o_dir
                   && fifo_count >= thr) begin
         o_service_interrupt_bit <= 1'b1;
      end else if (i_svc_clr) begin
         o_service_interrupt_bit <= 1'b0;
      end
   end

   // Error line falling edge, forward direction only
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         err_prev_q   <= 1'b1;
         o_fault_flag <= 1'b0;
      end else begin
         err_prev_q <= sync2_q[`ECPPF_SYNC_ERR];
         if (err_fall && !i_fault_int_dis && !o_dir) begin
            o_fault_flag <= 1'b1;
         end else if (i_fault_clr) begin
            o_fault_flag <= 1'b0;
         end
      end
   end

   // DMA request and interrupt line
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         o_port_dma_request <= 1'b0;
         o_irq              <= 1'b0;
      end else begin
         o_port_dma_request <= auto_on & i_dma_enable_bit
            & ~o_service_interrupt_bit
            & (o_dir ? ~o_fifo_empty : ~o_fifo_full);
         o_irq <= o_service_interrupt_bit | o_fault_flag;
      end
   end

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);

   sequence s_strobe_low;
      !o_host_write_strobe_n && !sync2_q[`ECPPF_SYNC_CMD];
   endsequence
   sequence s_tc_hit;
      auto_on && i_dma_enable_bit && i_dma_tc;
   endsequence

   a_flags_exclusive: assert property (
      !(o_fifo_full && o_fifo_empty))
      else $error("full and empty together");
   a_mode_legal: assert property (
      $changed(o_mode) && !is_basic($past(o_mode)) |-> is_basic(o_mode))
      else $error("illegal mode change");
   a_dir_in_ps2: assert property (
      $changed(o_dir) |-> $past(o_mode) == `ECPPF_MODE_PS2)
      else $error("direction changed outside mode 001");
   a_select_held: assert property (
      ecp_on && $past(ecp_on) |-> o_select_input_line_n)
      else $error("select-in asserted in extended mode");
   a_rev_request: assert property (
      ecp_on && $past(ecp_on) |-> o_reverse_direction_request_n == ~o_dir)
      else $error("reverse request wrong");
   a_drive_confirm: assert property (
      ecp_on && $past(ecp_on) && o_port_data_bus_oe
      |-> !o_dir && $past(sync2_q[`ECPPF_SYNC_CONF]))
      else $error("bus driven without confirm");
   a_strobe_hold: assert property (
      s_strobe_low ##0 (state_q == ecppf_pkg::ST_FWD_STROBE)
      && !i_mode_wr && auto_on |=> !o_host_write_strobe_n)
      else $error("strobe released before busy");
   a_tc_service: assert property (
      s_tc_hit |=> o_service_interrupt_bit ##1 !o_port_dma_request)
      else $error("terminal count did not stop DMA");
   a_fault_edge: assert property (
      err_fall && !i_fault_int_dis && !o_dir |=> o_fault_flag ##1 o_irq)
      else $error("error edge not flagged");
endmodule : ecppf_parallel_port
`default_nettype wire

// ### bench/ecppf_periph_model.sv
/*
 Peripheral model for the extended parallel port engine.
 Assumes the engine's pin outputs on the shared 25 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
module ecppf_periph_model (
   // Clock and stall control
   input  wire logic       i_sys_clk,
   input  wire logic       i_stall,
   // Reverse byte to offer, {command, data}
   input  wire logic       i_rev_go,
   input  wire logic [8:0] i_rev_word,
   // Host side pins
   input  wire logic       i_strobe_n,
   input  wire logic       i_auto_feed_n,
   input  wire logic       i_rev_req_n,
   input  wire logic [7:0] i_data,
   // Peripheral side pins
   output logic            o_busy,
   output logic            o_valid_n,
   output logic            o_confirm_n,
   output logic [7:0]      o_bus,
   // Captured byte, one-cycle pulse
   output logic            o_got,
   output logic [8:0]      o_word
);
   logic [7:0] bus_q;
   initial o_busy = 1'b0;
   initial o_got = 1'b0;
   initial o_valid_n = 1'b1;
   initial bus_q = 8'h00;
   // Reverse once confirmed: offer a byte, withdraw it on the host ack.
   // Forward: busy high while stalled or holding a byte
   always @(posedge i_sys_clk) begin
      o_got <= 1'b0;
      if (o_confirm_n === 1'b0) begin
         if (o_valid_n && !i_auto_feed_n && i_rev_go) begin
            o_valid_n <= 1'b0;
            o_busy    <= ~i_rev_word[8];
            bus_q     <= i_rev_word[7:0];
         end else if (!o_valid_n && i_auto_feed_n) begin
            o_valid_n <= 1'b1;
         end
      end else if (i_stall) begin
         o_busy <= 1'b1;
      end else if (!i_strobe_n && !o_busy) begin
         o_busy <= 1'b1;
         o_word <= {~i_auto_feed_n, i_data};
         o_got  <= 1'b1;
      end else if (i_strobe_n && o_busy) begin
         o_busy <= 1'b0;
      end
   end
   // Confirm follows the direction request
   always_ff @(posedge i_sys_clk) o_confirm_n <= i_rev_req_n;
   // Drives only after confirming reverse; else the inverse, never stale
   assign o_bus = o_confirm_n ? ~i_data : bus_q;
endmodule : ecppf_periph_model
`default_nettype wire

// ### bench/test_ecp_parallel_port_fifo.sv
/*
 Self-checking bench of the extended parallel port engine.
 Assumes the package, design and peripheral model compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module test_ecp_parallel_port_fifo;
   logic       clk = 0, rst_n = 0, mwr = 0, dwr = 0, dir = 0;
   logic       wv = 0, sel = 0, fdis = 0, fclr = 0, err_n = 1;
   logic       stall = 0, busy, conf_n, got, fe, ff, svc, flt, irq;
   logic       stb_n, af_n, rr_n, sl_n, oe, wrdy, rv;
   logic [2:0] mode = 0, om;
   logic [7:0] wd = 0, pd, pbus;
   logic [8:0] word, exp_q[$];
   logic       odir;
   logic       svclr = 0, dma = 0, tc = 0, rgo = 0, vld_n, dreq;
   logic [8:0] rw = 0;
   ecppf_pkg::ecppf_word_t   rword;
   // Idle software pins: strobe, auto-feed, init, select-in high
   ecppf_pkg::ecppf_swpins_t sw = 13'h1E00;
   int         n_fail = 0, checked = 0, n;
   always #20 clk = ~clk;
   ecppf_parallel_port DUT (
      .i_sys_clk(clk), .i_rst_n(rst_n), .i_mode(mode), .i_mode_wr(mwr),
      .i_dir(dir), .i_dir_wr(dwr), .i_dma_enable_bit(dma),
      .i_dma_tc(tc), .i_svc_clr(svclr), .i_fault_int_dis(fdis),
      .i_fault_clr(fclr), .i_fifo_threshold_config(4'h4),
      .i_sw_pins(sw), .i_wr_valid(wv), .i_wr_addr_sel(sel),
      .i_wr_data(wd), .o_wr_ready(wrdy), .o_rd_valid(rv),
      .o_rd_word(rword), .i_rd_ready(1'b1), .o_mode(om), .o_dir(odir),
      .o_fifo_full(ff), .o_fifo_empty(fe),
      .o_service_interrupt_bit(svc), .o_fault_flag(flt), .o_irq(irq),
      .o_port_dma_request(dreq), .o_host_write_strobe_n(stb_n),
      .o_auto_feed_line_n(af_n), .o_reverse_direction_request_n(rr_n),
      .o_select_input_line_n(sl_n), .o_port_data_bus(pd),
      .o_port_data_bus_oe(oe), .i_port_data_bus(pbus),
      .i_peripheral_valid_line_n(vld_n), .i_peripheral_cmd_flag(busy),
      .i_reverse_confirm_line_n(conf_n),
      .i_peripheral_error_line_n(err_n));
   ecppf_periph_model PER (
      .i_sys_clk(clk), .i_stall(stall), .i_rev_go(rgo), .i_rev_word(rw),
      .i_strobe_n(stb_n), .i_auto_feed_n(af_n), .i_rev_req_n(rr_n),
      .i_data(pd), .o_busy(busy), .o_valid_n(vld_n),
      .o_confirm_n(conf_n), .o_bus(pbus), .o_got(got),
      .o_word(word));
   // Compare and count
   task automatic chk(input logic [8:0] e, input logic [8:0] a);
      checked++;
      if (a !== e) begin
         n_fail++;
         $display("[FAIL] t=%0t exp=%h got=%h", $time, e, a);
      end
   endtask : chk
   task automatic step(input int c);
      repeat (c) @(posedge clk);
      #1;
   endtask : step
   task automatic report_and_stop;
      $display("checks=%0d mismatches=%0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : report_and_stop
   task automatic setm(input logic [2:0] m, input logic [2:0] e);
      mode = m;
      mwr = 1;
      step(1);
      mwr = 0;
      step(1);
      chk(e, om);
   endtask : setm
   task automatic setd(input logic d, input logic e);
      dir = d;
      dwr = 1;
      step(1);
      dwr = 0;
      step(1);
      chk(e, odir);
   endtask : setd
   // One byte in, waiting for room under a bound; valid stays up
   // so back-to-back calls never toggle it within one time step
   task automatic wr(input logic s, input logic [7:0] d);
      wv = 1;
      sel = s;
      wd = d;
      for (n = 0; n < 200 && wrdy !== 1'b1; n++) step(1);
      if (n == 200) begin n_fail++; report_and_stop(); end
      step(1);
      exp_q.push_back({s, d});
   endtask : wr
   task automatic drain;
      for (n = 0; n < 2000 && exp_q.size() > 0; n++) step(1);
      if (n == 2000) begin n_fail++; report_and_stop(); end
   endtask : drain
   // One reverse byte offered by the peripheral, read back by the host
   task automatic rev(input logic [8:0] w);
      rw = w;
      rgo = 1;
      for (n = 0; n < 200 && vld_n !== 1'b0; n++) step(1);
      rgo = 0;
      while (n < 200 && rv !== 1'b1) begin
         step(1);
         n++;
      end
      if (n == 200) begin n_fail++; report_and_stop(); end
      chk(w, rword);
   endtask : rev
   // Every byte seen at the pins must be the next one written
   always @(posedge clk) if (got) begin
      if (exp_q.size() == 0) chk(9'h1FF, word);
      else chk(exp_q.pop_front(), word);
   end
   initial begin
      step(5);
      rst_n = 1;
      chk(9'h1, fe);
      chk(9'h0, ff);
      chk(9'h0, {oe, wrdy, svc});
      $display("test reset done");
      setm(3'h3, 3'h3);
      setd(1'b1, 1'b0);
      setm(3'h2, 3'h3);
      setm(3'h1, 3'h1);
      setd(1'b1, 1'b1);
      setd(1'b0, 1'b0);
      setm(3'h2, 3'h2);
      setm(3'h3, 3'h2);
      setm(3'h0, 3'h0);
      chk(9'h0, wrdy);
      sw.init_n = 1'b0;
      step(2);
      chk(9'h0, rr_n);
      sw.init_n = 1'b1;
      $display("test modes done");
      setm(3'h3, 3'h3);
      step(4);
      chk(9'h3, {sl_n, rr_n});
      chk(9'h1, oe);
      wr(1'b1, 8'h05);
      wr(1'b0, 8'hA5);
      wv = 0;
      drain();
      step(6);
      chk(9'h3, {svc, irq});
      svclr = 1;
      step(1);
      svclr = 0;
      chk(9'h1, svc);
      $display("test forward done");
      stall = 1;
      step(4);
      for (int i = 0; i < 20 && wrdy === 1'b1; i++) wr(1'b0, 8'(i));
      wv = 0;
      step(2);
      // Sixteen stored plus the one parked at the pins
      chk(9'h11, 9'(exp_q.size()));
      chk(9'h1, ff);
      chk(9'h0, {fe, wrdy});
      stall = 0;
      drain();
      step(4);
      chk(9'h1, fe);
      $display("test fill done");
      fdis = 1;
      err_n = 0;
      step(6);
      chk(9'h0, flt);
      err_n = 1;
      fdis = 0;
      step(4);
      err_n = 0;
      step(6);
      chk(9'h1, flt);
      fclr = 1;
      step(1);
      fclr = 0;
      step(2);
      chk(9'h0, flt);
      $display("test fault done");
      dma = 1;
      svclr = 1;
      step(1);
      svclr = 0;
      step(2);
      chk(9'h2, {svc, dreq, irq});
      tc = 1;
      step(1);
      tc = 0;
      step(2);
      chk(9'h5, {svc, dreq, irq});
      dma = 0;
      setm(3'h0, 3'h0);
      svclr = 1;
      step(1);
      svclr = 0;
      step(2);
      chk(9'h0, {svc, irq});
      $display("test service done");
      setm(3'h1, 3'h1);
      setd(1'b1, 1'b1);
      setm(3'h3, 3'h3);
      step(2);
      chk(9'h0, {oe, rr_n});
      rev(9'h0A5);
      rev(9'h13C);
      $display("test reverse done");
      report_and_stop();
   end
endmodule : test_ecp_parallel_port_fifo
`default_nettype wire
